//--- mbg_pkg.sv
package mbg_pkg;
   // Address and table geometry
   localparam int ADDR_W = 24;
   localparam int SEG_N = 64;
   localparam int SEG_IDX_W = 6;
   localparam int HW_GRP_W = 8;
   localparam int SFR_ADDR_W = 8;

   // CPU mode codes, Gray along boot -> test -> firmware -> system -> user
   typedef enum logic [2:0] {
      MBG_MODE_BOOT = 3'h0,
      MBG_MODE_TEST = 3'h1,
      MBG_MODE_FW = 3'h3,
      MBG_MODE_SYS = 3'h2,
      MBG_MODE_USER = 3'h6
   } mbg_mode_e;

   // Memory operations
   typedef enum logic [2:0] {
      MBG_OP_READ = 3'h0,
      MBG_OP_WRITE = 3'h1,
      MBG_OP_EXEC = 3'h3,
      MBG_OP_VZERO = 3'h2,
      MBG_OP_VPROG = 3'h6
   } mbg_op_e;

   // Physical memory regions
   typedef enum logic [3:0] {
      MBG_RG_ROM_BOOTLDR = 4'h0,
      MBG_RG_ROM_FWOS = 4'h1,
      MBG_RG_ROM_OTHER = 4'h2,
      MBG_RG_SFLASH = 4'h3,
      MBG_RG_AFLASH_FROZEN = 4'h4,
      MBG_RG_AFLASH_MOD = 4'h5,
      MBG_RG_FW_EE = 4'h6,
      MBG_RG_APP_EE = 4'h7,
      MBG_RG_MFR_WONCE = 4'h8,
      MBG_RG_MFR_PROT = 4'h9,
      MBG_RG_MFR_BOOTLDR = 4'ha,
      MBG_RG_MFR_FUSE = 4'hb,
      MBG_RG_FW_RAM = 4'hc,
      MBG_RG_APP_RAM = 4'hd,
      MBG_RG_NONE = 4'hf
   } mbg_region_e;

   // SFR groups
   typedef enum logic [2:0] {
      MBG_SG_SEGCFG = 3'h0,
      MBG_SG_SYSMGT = 3'h1,
      MBG_SG_FWALL = 3'h2,
      MBG_SG_FWOS = 3'h3,
      MBG_SG_TEST = 3'h4,
      MBG_SG_HWCOMP = 3'h5,
      MBG_SG_CPU = 3'h6,
      MBG_SG_CPU_BANK = 3'h7
   } mbg_sfr_grp_e;

   // Physical map boundaries (plain defaults)
   localparam logic [ADDR_W-1:0] MAP_ROM_BOOTLDR_END = 24'h001000;
   localparam logic [ADDR_W-1:0] MAP_ROM_FWOS_END = 24'h008000;
   localparam logic [ADDR_W-1:0] MAP_ROM_END = 24'h040000;
   localparam logic [ADDR_W-1:0] MAP_SFLASH_END = 24'h060000;
   localparam logic [ADDR_W-1:0] MAP_AFLASH_END = 24'h200000;
   localparam logic [ADDR_W-1:0] MAP_FWEE_END = 24'h208000;
   localparam logic [ADDR_W-1:0] MAP_MFR_WONCE = 24'h208000;
   localparam logic [ADDR_W-1:0] MAP_MFR_PROT = 24'h208100;
   localparam logic [ADDR_W-1:0] MAP_MFR_BOOTLDR = 24'h208200;
   localparam logic [ADDR_W-1:0] MAP_MFR_FUSE = 24'h208300;
   localparam logic [ADDR_W-1:0] MAP_MFR_END = 24'h208400;
   localparam logic [ADDR_W-1:0] MAP_AEE_END = 24'h280000;
   localparam logic [ADDR_W-1:0] MAP_FWRAM_END = 24'h281000;
   localparam logic [ADDR_W-1:0] MAP_RAM_END = 24'h290000;
   // Protect-bit bytes sit in the upper half of the protected region
   localparam logic [ADDR_W-1:0] MAP_MFR_PROT_FLAGS = 24'h208180;

   // Segment entry rights field
   localparam int RIGHT_R = 0;
   localparam int RIGHT_W = 1;
   localparam int RIGHT_X = 2;

   typedef struct packed {
      logic [2:0] rights;
      logic [ADDR_W-1:0] lo;
      logic [ADDR_W-1:0] hi;
      logic [ADDR_W-1:0] offset;
      logic [HW_GRP_W-1:0] hw_rights;
   } mbg_seg_s;

   typedef struct packed {
      logic valid;
      mbg_op_e op;
      logic [ADDR_W-1:0] vaddr;
      logic [7:0] wdata;
   } mbg_mreq_s;

   typedef struct packed {
      logic valid;
      logic write;
      mbg_sfr_grp_e grp;
      logic [2:0] hw_idx;
      logic [SFR_ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } mbg_sreq_s;

   // Firewall register group as seen by the guard
   typedef struct packed {
      logic fl_check_en;
      logic ee_check_en;
      logic [HW_GRP_W-1:0] hw_rights;
      logic [ADDR_W-1:0] xram_base;
      logic [ADDR_W-1:0] xram_size;
   } mbg_fwall_s;

   localparam logic [2:0] RESET_MODE_BITS = 3'h0;
   localparam logic [7:0] READ_BLOCKED = 8'h00;
endpackage

//--- mbg_seg_match.sv
module mbg_seg_match
   import mbg_pkg::*;
(
   // Entry and address
   input wire mbg_seg_s seg,
   input wire logic [ADDR_W-1:0] vaddr,
   // Result
   output logic hit,
   output logic [ADDR_W-1:0] paddr
);
   always_comb begin
      // Entry with no rights counts as absent
      hit = (seg.rights != 3'h0) && (vaddr >= seg.lo) && (vaddr <= seg.hi);
      paddr = ADDR_W'(vaddr + seg.offset);
   end
endmodule

//--- mbg_guard.sv
// Contract
// - Mode from mode registers, one of five
// - Segment table holds up to 64 entries
// - Entry without rights is disabled
// - Read and write rights are coupled
// - Every CPU address translated to physical
// - Permission checked before memory is reached
// - Each SFR access checked against mode
// - HW rights from segment or firewall
// - Rejected SFR access raises exception
// - Protect bit blocks manufacturer byte writes
// - App flash split by config option
// - Boot reads/executes ROM except bootloader
// - Boot rights on support flash, EEPROM, RAM
// - Test: ROM no bootloader exec, rest full
// - Firmware rights on OS code, EEPROM, RAM
// - Firmware manufacturer-area special write rights
// - Verify-zero and program checks on NVM
// - Segment table pointer register held
// - Banked CPU regs for system and user
// - Peripheral gets the grant itself
// - Firewall settings govern firmware access
module mbg_guard
   import mbg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Mode registers and configuration
   input wire logic [2:0] mode_bits,
   input wire logic [ADDR_W-1:0] frozen_split,
   input wire logic [ADDR_W-1:0] seg_tbl_ptr_in,
   input wire logic seg_tbl_ptr_we,
   input wire mbg_fwall_s fwall,
   // Segment table load port
   input wire logic seg_we,
   input wire logic [SEG_IDX_W-1:0] seg_idx,
   input wire mbg_seg_s seg_in,
   // Memory request
   input wire mbg_mreq_s mreq,
   input wire logic [7:0] prot_byte,
   // SFR request
   input wire mbg_sreq_s sreq,
   // Memory side
   output logic mem_valid,
   output mbg_op_e mem_op,
   output logic [ADDR_W-1:0] mem_paddr,
   output logic [7:0] mem_wdata,
   output logic mem_fault,
   // SFR side
   output logic sfr_valid,
   output logic sfr_write,
   output logic [SFR_ADDR_W-1:0] sfr_addr,
   output logic [7:0] sfr_wdata,
   output logic sfr_bank_user,
   output logic sfr_exc,
   // Status
   output mbg_mode_e mode,
   output logic [ADDR_W-1:0] seg_tbl_ptr
);
   mbg_seg_s seg_tbl [SEG_N];
   mbg_mode_e next_mode;
   logic [ADDR_W-1:0] next_seg_tbl_ptr;
   logic [SEG_N-1:0] hits;
   logic [ADDR_W-1:0] paddrs [SEG_N];
   logic [SEG_IDX_W-1:0] cur_seg;
   logic [SEG_IDX_W-1:0] next_cur_seg;
   logic [SEG_IDX_W-1:0] hit_idx;
   logic any_hit;
   logic [ADDR_W-1:0] paddr;
   mbg_region_e region;
   logic allow_m;
   logic allow_s;
   logic next_mem_valid;
   logic next_mem_fault;
   logic next_sfr_valid;
   logic next_sfr_exc;
   logic [2:0] rx;

   genvar g;
   generate
      for (g = 0; g < SEG_N; g++) begin : g_seg
         mbg_seg_match u_match (
            .seg(seg_tbl[g]),
            .vaddr(mreq.vaddr),
            .hit(hits[g]),
            .paddr(paddrs[g])
         );
      end
   endgenerate

   // Table load; no reset so it maps to memory
   always_ff @(posedge clk) begin
      if (seg_we) begin
         seg_tbl[seg_idx] <= seg_in;
      end
   end

   // Lowest matching segment wins
   always_comb begin
      any_hit = 1'b0;
      hit_idx = '0;
      for (int i = SEG_N - 1; i >= 0; i--) begin
         if (hits[i]) begin
            any_hit = 1'b1;
            hit_idx = SEG_IDX_W'(i);
         end
      end
   end

   // Mode decode; unknown codes fall back to the least privileged mode
   always_comb begin
      case (mode_bits)
         3'h0: next_mode = MBG_MODE_BOOT;
         3'h1: next_mode = MBG_MODE_TEST;
         3'h3: next_mode = MBG_MODE_FW;
         3'h2: next_mode = MBG_MODE_SYS;
         default: next_mode = MBG_MODE_USER;
      endcase
      next_seg_tbl_ptr = seg_tbl_ptr_we ? seg_tbl_ptr_in : seg_tbl_ptr;
   end

   // Translation: user mode goes through the segments, others flat
   always_comb begin
      if (mode == MBG_MODE_USER) begin
         paddr = paddrs[hit_idx];
      end else begin
         paddr = mreq.vaddr;
      end
   end

   // Region decode of the physical address
   always_comb begin
      if (paddr < MAP_ROM_BOOTLDR_END) begin
         region = MBG_RG_ROM_BOOTLDR;
      end else if (paddr < MAP_ROM_FWOS_END) begin
         region = MBG_RG_ROM_FWOS;
      end else if (paddr < MAP_ROM_END) begin
         region = MBG_RG_ROM_OTHER;
      end else if (paddr < MAP_SFLASH_END) begin
         region = MBG_RG_SFLASH;
      end else if (paddr < frozen_split) begin
         region = MBG_RG_AFLASH_FROZEN;
      end else if (paddr < MAP_AFLASH_END) begin
         region = MBG_RG_AFLASH_MOD;
      end else if (paddr < MAP_FWEE_END) begin
         region = MBG_RG_FW_EE;
      end else if (paddr < MAP_MFR_PROT) begin
         region = MBG_RG_MFR_WONCE;
      end else if (paddr < MAP_MFR_BOOTLDR) begin
         region = MBG_RG_MFR_PROT;
      end else if (paddr < MAP_MFR_FUSE) begin
         region = MBG_RG_MFR_BOOTLDR;
      end else if (paddr < MAP_MFR_END) begin
         region = MBG_RG_MFR_FUSE;
      end else if (paddr < MAP_AEE_END) begin
         region = MBG_RG_APP_EE;
      end else if (paddr < MAP_FWRAM_END) begin
         region = MBG_RG_FW_RAM;
      end else if (paddr < MAP_RAM_END) begin
         region = MBG_RG_APP_RAM;
      end else begin
         region = MBG_RG_NONE;
      end
   end

   // Memory permission; rx = {exec, write, read}
   always_comb begin
      rx = 3'h0;
      case (mode)
         MBG_MODE_BOOT: begin
            case (region)
               MBG_RG_ROM_FWOS, MBG_RG_ROM_OTHER: rx = 3'h5;
               MBG_RG_SFLASH: rx = 3'h5;
               MBG_RG_FW_EE: rx = 3'h3;
               MBG_RG_MFR_WONCE, MBG_RG_MFR_PROT, MBG_RG_MFR_BOOTLDR,
               MBG_RG_MFR_FUSE, MBG_RG_FW_RAM: rx = 3'h7;
               default: rx = 3'h0;
            endcase
         end
         MBG_MODE_TEST: begin
            case (region)
               MBG_RG_ROM_BOOTLDR: rx = 3'h1;
               MBG_RG_ROM_FWOS, MBG_RG_ROM_OTHER: rx = 3'h5;
               MBG_RG_NONE: rx = 3'h0;
               default: rx = 3'h7;
            endcase
         end
         MBG_MODE_FW: begin
            case (region)
               MBG_RG_ROM_FWOS: rx = 3'h5;
               MBG_RG_SFLASH, MBG_RG_FW_RAM: rx = 3'h7;
               MBG_RG_FW_EE: rx = 3'h3;
               MBG_RG_MFR_FUSE: rx = 3'h5;
               MBG_RG_MFR_WONCE, MBG_RG_MFR_PROT, MBG_RG_MFR_BOOTLDR: rx = 3'h7;
               MBG_RG_APP_RAM: rx = ((paddr >= fwall.xram_base) &&
                  (paddr < ADDR_W'(fwall.xram_base + fwall.xram_size))) ? 3'h3 : 3'h0;
               default: rx = 3'h0;
            endcase
         end
         MBG_MODE_SYS: begin
            // Firmware areas stay closed to system code
            case (region)
               MBG_RG_AFLASH_FROZEN, MBG_RG_MFR_FUSE: rx = 3'h5;
               MBG_RG_AFLASH_MOD, MBG_RG_APP_EE, MBG_RG_APP_RAM: rx = 3'h7;
               MBG_RG_MFR_WONCE, MBG_RG_MFR_PROT: rx = 3'h7;
               MBG_RG_MFR_BOOTLDR: rx = 3'h5;
               default: rx = 3'h0;
            endcase
         end
         default: begin
            rx = any_hit ? seg_tbl[hit_idx].rights : 3'h0;
            // Read implies write and back, outside frozen flash
            if (region != MBG_RG_AFLASH_FROZEN && (rx[RIGHT_R] || rx[RIGHT_W])) begin
               rx[RIGHT_R] = 1'b1;
               rx[RIGHT_W] = 1'b1;
            end
         end
      endcase
   end

   // Operation check
   always_comb begin
      case (mreq.op)
         MBG_OP_READ: allow_m = rx[RIGHT_R] || rx[RIGHT_W];
         MBG_OP_WRITE: begin
            allow_m = rx[RIGHT_W] || rx[RIGHT_R];
            if (region == MBG_RG_ROM_BOOTLDR || region == MBG_RG_ROM_FWOS ||
               region == MBG_RG_ROM_OTHER || region == MBG_RG_AFLASH_FROZEN) begin
               allow_m = 1'b0;
            end
            // Write-once bytes accept writes only while still erased, except in boot and test mode
            if (region == MBG_RG_MFR_WONCE && prot_byte != READ_BLOCKED &&
               mode != MBG_MODE_BOOT && mode != MBG_MODE_TEST) begin
               allow_m = 1'b0;
            end
            if (region == MBG_RG_MFR_PROT && prot_byte[0]) begin
               allow_m = 1'b0;
            end
         end
         MBG_OP_EXEC: allow_m = rx[RIGHT_X];
         MBG_OP_VZERO: begin
            if (mode == MBG_MODE_FW && (region == MBG_RG_AFLASH_FROZEN ||
               region == MBG_RG_AFLASH_MOD)) begin
               allow_m = fwall.fl_check_en;
            end else if (mode == MBG_MODE_FW && region == MBG_RG_APP_EE) begin
               allow_m = fwall.ee_check_en;
            end else begin
               allow_m = rx[RIGHT_R];
            end
         end
         MBG_OP_VPROG: begin
            if (mode == MBG_MODE_FW && (region == MBG_RG_AFLASH_FROZEN ||
               region == MBG_RG_AFLASH_MOD)) begin
               allow_m = fwall.fl_check_en;
            end else begin
               allow_m = rx[RIGHT_R] && region != MBG_RG_APP_EE;
            end
         end
         default: allow_m = 1'b0;
      endcase
      next_mem_valid = mreq.valid && allow_m;
      next_mem_fault = mreq.valid && !allow_m;
   end

   // SFR check by mode and group
   always_comb begin
      allow_s = 1'b0;
      case (mode)
         MBG_MODE_BOOT: allow_s = !(sreq.grp inside {MBG_SG_SEGCFG, MBG_SG_CPU_BANK,
            MBG_SG_TEST}) || (sreq.grp == MBG_SG_TEST && sreq.addr[SFR_ADDR_W-1]);
         MBG_MODE_TEST: allow_s = !(sreq.grp inside {MBG_SG_SEGCFG, MBG_SG_CPU_BANK});
         MBG_MODE_FW: begin
            case (sreq.grp)
               MBG_SG_FWALL: allow_s = !sreq.write;
               MBG_SG_FWOS, MBG_SG_CPU: allow_s = 1'b1;
               MBG_SG_HWCOMP: allow_s = fwall.hw_rights[sreq.hw_idx];
               default: allow_s = 1'b0;
            endcase
         end
         MBG_MODE_SYS: allow_s = sreq.grp inside {MBG_SG_SEGCFG, MBG_SG_SYSMGT, MBG_SG_FWALL,
            MBG_SG_HWCOMP, MBG_SG_CPU, MBG_SG_CPU_BANK};
         default: begin
            case (sreq.grp)
               MBG_SG_CPU, MBG_SG_CPU_BANK: allow_s = 1'b1;
               MBG_SG_HWCOMP: allow_s = seg_tbl[cur_seg].hw_rights[sreq.hw_idx];
               default: allow_s = 1'b0;
            endcase
         end
      endcase
      next_sfr_valid = sreq.valid && allow_s;
      next_sfr_exc = sreq.valid && !allow_s;
      // Segment that last fetched code sets user hardware rights
      next_cur_seg = (mreq.valid && mreq.op == MBG_OP_EXEC && any_hit &&
         mode == MBG_MODE_USER) ? hit_idx : cur_seg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode <= mbg_mode_e'(RESET_MODE_BITS);
         seg_tbl_ptr <= '0;
         cur_seg <= '0;
         mem_valid <= 1'b0;
         mem_fault <= 1'b0;
         mem_op <= MBG_OP_READ;
         mem_paddr <= '0;
         mem_wdata <= '0;
         sfr_valid <= 1'b0;
         sfr_write <= 1'b0;
         sfr_addr <= '0;
         sfr_wdata <= '0;
         sfr_bank_user <= 1'b0;
         sfr_exc <= 1'b0;
      end else begin
         mode <= next_mode;
         seg_tbl_ptr <= next_seg_tbl_ptr;
         cur_seg <= next_cur_seg;
         mem_valid <= next_mem_valid;
         mem_fault <= next_mem_fault;
         mem_op <= mreq.op;
         // Denied requests leave address and data at zero
         mem_paddr <= next_mem_valid ? paddr : '0;
         mem_wdata <= next_mem_valid ? mreq.wdata : READ_BLOCKED;
         sfr_valid <= next_sfr_valid;
         sfr_write <= next_sfr_valid && sreq.write;
         sfr_addr <= next_sfr_valid ? sreq.addr : '0;
         sfr_wdata <= next_sfr_valid ? sreq.wdata : READ_BLOCKED;
         sfr_bank_user <= (mode == MBG_MODE_USER);
         sfr_exc <= next_sfr_exc;
      end
   end
endmodule

//--- mbg_cpu_model.sv
module mbg_cpu_model
   import mbg_pkg::*;
(
   // Clock
   input wire logic clk,
   // Requests toward the guard
   output mbg_mreq_s mreq,
   output mbg_sreq_s sreq
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      mreq = '0;
      sreq = '0;
   end
   // Caller sits just after a rising edge; the request is taken at the next one
   task automatic mem(mbg_op_e op, logic [ADDR_W-1:0] va, logic [7:0] wd);
      mreq = '{1'b1, op, va, wd};
      sreq.valid = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic sfr(logic w, mbg_sfr_grp_e g, logic [2:0] i, logic [7:0] a, logic [7:0] wd);
      sreq = '{1'b1, w, g, i, a, wd};
      mreq.valid = 1'b0;
      @(posedge clk);
      #1;
   endtask
   // Valid stays up between calls so back-to-back needs no gap; idle garbles the payload
   task automatic idle();
      mreq.valid = 1'b0;
      mreq.vaddr = ~mreq.vaddr;
      sreq.valid = 1'b0;
      sreq.wdata = ~sreq.wdata;
   endtask
endmodule

//--- mbg_guard_properties.sv
module mbg_guard_checker
   import mbg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Inputs
   input wire logic [2:0] mode_bits,
   input wire logic [ADDR_W-1:0] seg_tbl_ptr_in,
   input wire logic seg_tbl_ptr_we,
   input wire mbg_mreq_s mreq,
   input wire mbg_sreq_s sreq,
   // Outputs
   input wire logic mem_valid,
   input wire logic [ADDR_W-1:0] mem_paddr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_fault,
   input wire logic sfr_valid,
   input wire logic sfr_write,
   input wire logic [SFR_ADDR_W-1:0] sfr_addr,
   input wire logic sfr_bank_user,
   input wire logic sfr_exc,
   input wire mbg_mode_e mode,
   input wire logic [ADDR_W-1:0] seg_tbl_ptr
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   function automatic mbg_mode_e dec(logic [2:0] b);
      case (b)
         3'h0: return MBG_MODE_BOOT;
         3'h1: return MBG_MODE_TEST;
         3'h3: return MBG_MODE_FW;
         3'h2: return MBG_MODE_SYS;
         default: return MBG_MODE_USER;
      endcase
   endfunction
   mem_answer_a: assert property (mreq.valid |=> mem_valid ^ mem_fault)
      else $error("memory request without a single answer");
   mem_cause_a: assert property ((mem_valid || mem_fault) |-> $past(mreq.valid))
      else $error("memory answer without request");
   deny_quiet_a: assert property (mem_fault |-> !mem_valid && mem_paddr == '0 && mem_wdata == '0)
      else $error("denied access leaks address or data");
   sfr_answer_a: assert property (sreq.valid |=> sfr_valid ^ sfr_exc)
      else $error("register request without a single answer");
   exc_quiet_a: assert property (sfr_exc |-> $past(sreq.valid) && !sfr_write && sfr_addr == '0)
      else $error("exception not clean");
   sfr_dir_a: assert property (sfr_valid |-> sfr_write == $past(sreq.write))
      else $error("granted register access changed direction");
   mode_follow_a: assert property (!$past(rst) |-> mode == dec($past(mode_bits)))
      else $error("mode does not follow mode bits");
   bank_user_a: assert property (!$past(rst) |-> sfr_bank_user == ($past(mode) == MBG_MODE_USER))
      else $error("bank select wrong");
   ptr_load_a: assert property (seg_tbl_ptr_we |=> seg_tbl_ptr == $past(seg_tbl_ptr_in))
      else $error("table pointer not loaded");
   ptr_hold_a: assert property (!seg_tbl_ptr_we |=> $stable(seg_tbl_ptr))
      else $error("table pointer moved");
   cover property (mem_fault);
   cover property (sfr_exc);
   cover property (mem_valid ##1 mem_valid);
endmodule

bind mbg_guard mbg_guard_checker chk (
   .clk(clk), .rst(rst), .mode_bits(mode_bits), .seg_tbl_ptr_in(seg_tbl_ptr_in),
   .seg_tbl_ptr_we(seg_tbl_ptr_we), .mreq(mreq), .sreq(sreq), .mem_valid(mem_valid),
   .mem_paddr(mem_paddr), .mem_wdata(mem_wdata), .mem_fault(mem_fault),
   .sfr_valid(sfr_valid), .sfr_write(sfr_write), .sfr_addr(sfr_addr),
   .sfr_bank_user(sfr_bank_user), .sfr_exc(sfr_exc), .mode(mode), .seg_tbl_ptr(seg_tbl_ptr)
);

//--- test_mode_based_memory_sfr_guard.sv
module test_mode_based_memory_sfr_guard;
   import mbg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic ok;
      mbg_op_e op;
      logic [ADDR_W-1:0] pa;
      logic [7:0] wd;
   } mbg_exp_s;
   localparam mbg_op_e rd = MBG_OP_READ;
   localparam mbg_op_e wr = MBG_OP_WRITE;
   localparam mbg_op_e ex = MBG_OP_EXEC;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] mode_bits = 3'h0;
   logic [ADDR_W-1:0] ptr_in = '0;
   logic ptr_we = 1'b0;
   mbg_fwall_s fwall = '0;
   logic seg_we = 1'b0;
   logic [SEG_IDX_W-1:0] seg_idx = '0;
   mbg_seg_s seg_in = '0;
   logic [7:0] prot_byte = 8'h00;
   mbg_mreq_s mreq;
   mbg_sreq_s sreq;
   logic mem_valid, mem_fault, sfr_valid, sfr_write, sfr_bank_user, sfr_exc;
   mbg_op_e mem_op;
   mbg_mode_e mode;
   logic [ADDR_W-1:0] mem_paddr, seg_tbl_ptr;
   logic [7:0] mem_wdata, sfr_wdata, hw;
   logic [SFR_ADDR_W-1:0] sfr_addr;
   mbg_exp_s mq[$];
   mbg_exp_s sq[$];
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;

   always #5 clk = ~clk;

   mbg_cpu_model cpu (.clk(clk), .mreq(mreq), .sreq(sreq));
   mbg_guard uut (
      .clk(clk), .rst(rst), .mode_bits(mode_bits), .frozen_split(24'h080000),
      .seg_tbl_ptr_in(ptr_in), .seg_tbl_ptr_we(ptr_we), .fwall(fwall), .seg_we(seg_we),
      .seg_idx(seg_idx), .seg_in(seg_in), .mreq(mreq), .prot_byte(prot_byte), .sreq(sreq),
      .mem_valid(mem_valid), .mem_op(mem_op), .mem_paddr(mem_paddr), .mem_wdata(mem_wdata),
      .mem_fault(mem_fault), .sfr_valid(sfr_valid), .sfr_write(sfr_write),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_bank_user(sfr_bank_user),
      .sfr_exc(sfr_exc), .mode(mode), .seg_tbl_ptr(seg_tbl_ptr)
   );

   task automatic fail(string m);
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task automatic cmp(logic [ADDR_W-1:0] got, logic [ADDR_W-1:0] exp, string m);
      check_count++;
      if (got !== exp) fail(m);
   endtask
   task automatic cmp_mem(mbg_exp_s e);
      check_count++;
      if (mem_valid !== e.ok || mem_fault !== !e.ok || mem_paddr !== e.pa
          || (e.ok && mem_op !== e.op) || ((!e.ok || e.op == wr) && mem_wdata !== e.wd))
         fail("memory answer");
   endtask
   task automatic cmp_sfr(mbg_exp_s e);
      check_count++;
      if (sfr_valid !== e.ok || sfr_exc !== !e.ok || sfr_write !== (e.ok && e.op == wr)
          || sfr_addr !== e.pa[7:0] || ((!e.ok || e.op == wr) && sfr_wdata !== e.wd))
         fail("register answer");
   endtask

   // Results are only looked at mid-cycle, once the registered outputs settle
   always @(negedge clk) begin
      // Unknown strobes count as answers so they reach a compare
      if (mem_valid !== 1'b0 || mem_fault !== 1'b0) begin
         if (mq.size() == 0) fail("memory answer without request");
         else cmp_mem(mq.pop_front());
      end
      if (sfr_valid !== 1'b0 || sfr_exc !== 1'b0) begin
         if (sq.size() == 0) fail("register answer without request");
         else cmp_sfr(sq.pop_front());
      end
   end

   task automatic mem(mbg_op_e op, logic [ADDR_W-1:0] va, logic [ADDR_W-1:0] o, logic ok);
      logic [7:0] wd;
      wd = 8'($urandom);
      mq.push_back('{ok, op, ok ? va + o : 24'h0, ok ? wd : 8'h00});
      cpu.mem(op, va, wd);
   endtask
   task automatic sfr(logic w, mbg_sfr_grp_e g, logic [2:0] i, logic t, logic ok);
      logic [7:0] a, wd;
      a = {t, 7'($urandom)};
      wd = 8'($urandom);
      sq.push_back('{ok, w ? wr : rd, ok ? {16'h0, a} : 24'h0, ok ? wd : 8'h00});
      cpu.sfr(w, g, i, a, wd);
   endtask
   task automatic set_mode(logic [2:0] b, mbg_mode_e m);
      cpu.idle();
      mode_bits = b;
      @(posedge clk);
      #1;
      cmp(24'(mode), 24'(m), "mode");
   endtask
   // Leaves seg_we high so consecutive loads need no gap
   task automatic seg(int i, logic [2:0] r, logic [ADDR_W-1:0] lo, logic [ADDR_W-1:0] o,
                      logic [7:0] h);
      seg_we = 1'b1;
      seg_idx = 6'(i);
      seg_in = '{r, lo, lo + 24'h000fff, o, h};
      @(posedge clk);
      #1;
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail("timeout");
         finish_test();
      end
   end

   initial begin
      void'($urandom(20839));
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      ptr_in = 24'($urandom);
      ptr_we = 1'b1;
      @(posedge clk);
      #1;
      ptr_we = 1'b0;
      cmp(seg_tbl_ptr, ptr_in, "table pointer");
      set_mode(3'h0, MBG_MODE_BOOT);
      mem(rd, 24'h010000, 24'h0, 1'b1);
      mem(ex, 24'h000100, 24'h0, 1'b0);
      mem(wr, 24'h010000, 24'h0, 1'b0);
      mem(ex, 24'h040100, 24'h0, 1'b1);
      mem(wr, 24'h200010, 24'h0, 1'b1);
      mem(ex, 24'h200010, 24'h0, 1'b0);
      mem(wr, 24'h208250, 24'h0, 1'b1);
      mem(ex, 24'h280010, 24'h0, 1'b1);
      mem(rd, 24'h285000, 24'h0, 1'b0);
      sfr(1'b0, MBG_SG_SEGCFG, 3'h0, 1'b0, 1'b0);
      sfr(1'b1, MBG_SG_TEST, 3'h0, 1'b0, 1'b0);
      sfr(1'b1, MBG_SG_TEST, 3'h0, 1'b1, 1'b1);
      sfr(1'b1, MBG_SG_CPU_BANK, 3'h0, 1'b0, 1'b0);
      set_mode(3'h1, MBG_MODE_TEST);
      mem(rd, 24'h000100, 24'h0, 1'b1);
      mem(ex, 24'h000100, 24'h0, 1'b0);
      mem(wr, 24'h100000, 24'h0, 1'b1);
      mem(rd, 24'h230000, 24'h0, 1'b1);
      mem(wr, 24'h230000, 24'h0, 1'b1);
      mem(ex, 24'h28a000, 24'h0, 1'b1);
      sfr(1'b1, MBG_SG_TEST, 3'h0, 1'b0, 1'b1);
      sfr(1'b1, MBG_SG_SEGCFG, 3'h0, 1'b1, 1'b0);
      hw = 8'($urandom);
      fwall = '{1'b0, 1'b1, hw, 24'h28e000, 24'h000100};
      set_mode(3'h3, MBG_MODE_FW);
      mem(ex, 24'h002000, 24'h0, 1'b1);
      mem(rd, 24'h010000, 24'h0, 1'b0);
      mem(wr, 24'h041000, 24'h0, 1'b1);
      mem(wr, 24'h200100, 24'h0, 1'b1);
      mem(ex, 24'h200100, 24'h0, 1'b0);
      mem(ex, 24'h280100, 24'h0, 1'b1);
      mem(wr, 24'h230000, 24'h0, 1'b0);
      mem(rd, 24'h208010, 24'h0, 1'b1);
      mem(wr, 24'h208210, 24'h0, 1'b1);
      prot_byte = 8'h01;
      mem(wr, 24'h208010, 24'h0, 1'b0);
      mem(wr, 24'h208110, 24'h0, 1'b0);
      prot_byte = 8'hfe;
      mem(wr, 24'h208010, 24'h0, 1'b0);
      mem(wr, 24'h208110, 24'h0, 1'b1);
      prot_byte = 8'h00;
      mem(wr, 24'h208010, 24'h0, 1'b1);
      for (int i = 0; i < 2; i++) begin
         cpu.idle();
         fwall.fl_check_en = i[0];
         fwall.ee_check_en = !i[0];
         @(posedge clk);
         #1;
         mem(MBG_OP_VZERO, 24'h100000, 24'h0, i[0]);
         mem(MBG_OP_VPROG, 24'h100040, 24'h0, i[0]);
         mem(MBG_OP_VZERO, 24'h230000, 24'h0, !i[0]);
      end
      for (int i = 0; i < 8; i++) sfr(1'b1, MBG_SG_HWCOMP, 3'(i), 1'b0, hw[i]);
      sfr(1'b0, MBG_SG_FWALL, 3'h0, 1'b0, 1'b1);
      sfr(1'b1, MBG_SG_FWALL, 3'h0, 1'b0, 1'b0);
      sfr(1'b1, MBG_SG_FWOS, 3'h0, 1'b1, 1'b1);
      sfr(1'b0, MBG_SG_CPU_BANK, 3'h0, 1'b0, 1'b0);
      set_mode(3'h2, MBG_MODE_SYS);
      sfr(1'b1, MBG_SG_SEGCFG, 3'h0, 1'b0, 1'b1);
      cmp(24'(sfr_bank_user), 24'h0, "bank select");
      // Drop the standing register request before the table loads
      cpu.idle();
      // Junk in disabled entries must never win over the enabled one
      for (int i = 0; i < SEG_N; i++) seg(i, 3'h0, 24'($urandom), 24'($urandom), 8'hff);
      hw = 8'($urandom);
      seg(5, 3'h0, 24'h400000, 24'h0, 8'hff);
      seg(62, 3'h5, 24'h410000, 24'hd00000, hw);
      seg(63, 3'h1, 24'h400000, 24'he85000, 8'h00);
      seg_we = 1'b0;
      set_mode(3'h6, MBG_MODE_USER);
      mem(rd, 24'h400010, 24'he85000, 1'b1);
      mem(wr, 24'h400ff0, 24'he85000, 1'b1);
      mem(rd, 24'h600000, 24'h0, 1'b0);
      mem(ex, 24'h410020, 24'hd00000, 1'b1);
      for (int i = 0; i < 8; i++) sfr(1'b1, MBG_SG_HWCOMP, 3'(i), 1'b0, hw[i]);
      sfr(1'b0, MBG_SG_CPU_BANK, 3'h0, 1'b0, 1'b1);
      sfr(1'b1, MBG_SG_SYSMGT, 3'h0, 1'b0, 1'b0);
      cmp(24'(sfr_bank_user), 24'h1, "bank select");
      set_mode(3'h7, MBG_MODE_USER);
      repeat (3) @(posedge clk);
      #1;
      cmp(24'(mq.size() + sq.size()), 24'h0, "answers missing");
      finish_test();
   end
endmodule
